// [src/ceb_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - strobe low with memory address valid
// - every word is two byte cycles
// - low address bit 0 then 1
// - read raises input direction with strobe
// - write strobe stays high in reads
// - not-ready memory stretches cycle with waits
// - after read, data stays input one clock
// - write strobe low with data and address
// - hold taken at next non-memory clock
// - following memory cycle completes before hold; here idle takes hold before any new request
// - hold acknowledged high, buses floated
// - hold release resumes processing
// - hold latency bounded by 13 plus waits
// - bit transfer reasserts address after hold
// - bit address on A2-A12, data A13
// - one strobe in second clock per output bit
// - bit input sampled next clock, no strobe
// - code sampled twice, latched when equal
module ceb_bus_if
    import ceb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Core request
    input  wire logic       req_valid,
    input  wire ceb_req_s   req,
    output logic            req_ready,
    // Core answer
    output logic            rsp_valid,
    input  wire logic       rsp_ready,
    output logic [15:0]     rsp_data,
    // Memory bus, addr_o[0] is A13
    output logic [13:0]     addr_o,
    output logic            bus_oe,
    input  wire logic [7:0] data_i,
    output logic [7:0]      data_o,
    output logic            data_oe,
    output logic            memory_cycle_strobe_n,
    output logic            write_strobe_n,
    output logic            bus_input_direction,
    input  wire logic       mem_ready,
    // Bus hold
    input  wire logic       hold_req_n,
    output logic            bus_release_ack,
    // Bit serial port
    output logic            bit_io_strobe,
    input  wire logic       bit_in,
    // Interrupt code
    input  wire logic [2:0] interrupt_level_code,
    output logic [2:0]      int_level,
    output logic            phase3_n
);

    logic [1:0]  rs;
    logic        rst_q;
    ceb_state_e  st, next_st;
    ceb_req_s    op, next_op;
    logic        byte_q, next_byte;
    logic [7:0]  lo, next_lo;
    logic [3:0]  bidx, next_bidx;
    logic [15:0] sh, next_sh;
    logic        resume, next_resume;
    logic        push;
    logic [15:0] push_data;
    logic [13:0] next_addr;
    logic [7:0]  next_dout;
    logic        next_oe, next_doe, next_mem_n, next_we_n, next_bus_input_direction, next_ack, next_stb, next_ready;
    logic        hv, next_hv, sv, next_sv, pop;
    logic [15:0] next_hd, sd, next_sd;
    logic [1:0]  ph, next_ph;
    logic [2:0]  s4, next_s4, s2, next_s2, next_lvl;
    logic        agree, next_agree, next_p3n;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs <= 2'b00;
        end else begin
            rs <= {rs[0], 1'b1};
        end
    end
    assign rst_q = rs[1];

    // Bus engine next state and pin values
    always_comb begin
        next_st     = st;
        next_op     = op;
        next_byte   = byte_q;
        next_lo     = lo;
        next_bidx   = bidx;
        next_sh     = sh;
        next_resume = resume;
        push        = 1'b0;
        push_data   = 16'h0000;
        unique case (st)
            S_IDLE: begin
                if (!hold_req_n) begin
                    next_st     = S_HOLD;
                    next_resume = 1'b0;
                end else if (req_valid && req_ready) begin
                    next_op   = req;
                    next_byte = 1'b0;
                    next_bidx = BIDX_RST;
                    next_st   = (req.kind == K_RD || req.kind == K_WR) ? S_MEM : S_BADR;
                end
            end
            S_MEM: begin
                // Waits until ready, second byte always follows
                if (mem_ready) begin
                    if (!byte_q) begin
                        next_byte = 1'b1;
                        next_lo   = data_i;
                    end else begin
                        next_sh = {8'h00, data_i};
                        next_st = (op.kind == K_RD) ? S_TURN : S_IDLE;
                    end
                end
            end
            S_TURN: begin
                push      = 1'b1;
                push_data = {lo, sh[7:0]};
                next_st   = S_IDLE;
            end
            S_BADR: begin
                if (!hold_req_n) begin
                    next_st     = S_HOLD;
                    next_resume = 1'b1;
                end else begin
                    next_st = S_BSTB;
                end
            end
            S_BSTB: begin
                if (op.kind == K_BIN) begin
                    next_sh[bidx] = bit_in;
                end
                next_bidx = bidx + 4'h1;
                if (bidx == 4'(op.cnt - 4'h1)) begin
                    next_st   = S_IDLE;
                    push      = (op.kind == K_BIN);
                    push_data = next_sh;
                end else begin
                    next_st = S_BADR;
                end
            end
            S_HOLD: begin
                if (hold_req_n) begin
                    next_st = resume ? S_BRE : S_IDLE;
                end
            end
            S_BRE: next_st = S_BADR;
            default: next_st = S_IDLE;
        endcase

        // Pins follow the state being entered
        next_ack   = (next_st == S_HOLD);
        next_oe    = !next_ack;
        next_mem_n = 1'b1;
        next_we_n  = 1'b1;
        next_bus_input_direction  = 1'b0;
        next_doe   = 1'b0;
        next_dout  = DATA_RST;
        next_addr  = ADDR_RST;
        next_stb   = 1'b0;
        if (next_st == S_MEM) begin
            next_mem_n = 1'b0;
            next_addr  = {next_op.addr, next_byte};
            next_bus_input_direction  = (next_op.kind == K_RD);
            next_we_n  = (next_op.kind != K_WR);
            next_doe   = (next_op.kind == K_WR);
            next_dout  = next_byte ? next_op.wdata[7:0] : next_op.wdata[15:8];
        end else if (next_st == S_BADR || next_st == S_BSTB || next_st == S_BRE) begin
            next_addr = {2'h0, 11'(next_op.addr[10:0] + {7'h00, next_bidx}),
                         next_op.wdata[next_bidx] & (next_op.kind == K_BOUT)};
            next_stb  = (next_st == S_BSTB) && (next_op.kind == K_BOUT);
        end
        next_ready = (next_st == S_IDLE) && !(next_hv && next_sv);
    end

    // Bus engine and pin registers
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            st                    <= S_IDLE;
            op                    <= '0;
            byte_q                <= 1'b0;
            lo                    <= DATA_RST;
            bidx                  <= BIDX_RST;
            sh                    <= 16'h0000;
            resume                <= 1'b0;
            addr_o                <= ADDR_RST;
            bus_oe                <= 1'b1;
            data_o                <= DATA_RST;
            data_oe               <= 1'b0;
            memory_cycle_strobe_n <= 1'b1;
            write_strobe_n        <= 1'b1;
            bus_input_direction   <= 1'b0;
            bus_release_ack       <= 1'b0;
            bit_io_strobe         <= 1'b0;
            req_ready             <= 1'b0;
        end else if (ce) begin
            st                    <= next_st;
            op                    <= next_op;
            byte_q                <= next_byte;
            lo                    <= next_lo;
            bidx                  <= next_bidx;
            sh                    <= next_sh;
            resume                <= next_resume;
            addr_o                <= next_addr;
            bus_oe                <= next_oe;
            data_o                <= next_dout;
            data_oe               <= next_doe;
            memory_cycle_strobe_n <= next_mem_n;
            write_strobe_n        <= next_we_n;
            bus_input_direction   <= next_bus_input_direction;
            bus_release_ack       <= next_ack;
            bit_io_strobe         <= next_stb;
            req_ready             <= next_ready;
        end
    end

    // Two-entry answer buffer, head is the output register
    always_comb begin
        pop     = hv && rsp_ready;
        next_hv = hv;
        next_sv = sv;
        next_hd = rsp_data;
        next_sd = sd;
        if (pop) begin
            if (sv) begin
                next_hd = sd;
                next_sv = push;
                next_sd = push_data;
            end else begin
                next_hv = push;
                next_hd = push_data;
            end
        end else if (push) begin
            if (!hv) begin
                next_hv = 1'b1;
                next_hd = push_data;
            end else begin
                next_sv = 1'b1;
                next_sd = push_data;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            hv       <= 1'b0;
            sv       <= 1'b0;
            rsp_data <= 16'h0000;
            sd       <= 16'h0000;
        end else if (ce) begin
            hv       <= next_hv;
            sv       <= next_sv;
            rsp_data <= next_hd;
            sd       <= next_sd;
        end
    end
    assign rsp_valid = hv;

    // Four-phase counter and filtered interrupt code
    always_comb begin
        next_ph    = ph + 2'h1;
        next_s4    = s4;
        next_s2    = s2;
        next_agree = agree;
        next_lvl   = int_level;
        if (ph == PH4) begin
            next_s4 = interrupt_level_code;
        end
        if (ph == PH2) begin
            next_s2    = interrupt_level_code;
            next_agree = (s4 == interrupt_level_code);
        end
        if (ph == PH1 && agree) begin
            next_lvl = s2;
        end
        next_p3n = (next_ph != PH3);
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            ph        <= PH1;
            s4        <= LVL_RST;
            s2        <= LVL_RST;
            agree     <= 1'b0;
            int_level <= LVL_RST;
            phase3_n  <= 1'b1;
        end else if (ce) begin
            ph        <= next_ph;
            s4        <= next_s4;
            s2        <= next_s2;
            agree     <= next_agree;
            int_level <= next_lvl;
            phase3_n  <= next_p3n;
        end
    end

    // Hold latency counter, wait clocks excluded
    logic [4:0] hcnt;
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            hcnt <= 5'h00;
        end else if (ce) begin
            if (hold_req_n || st == S_HOLD) begin
                hcnt <= 5'h00;
            end else if (!(st == S_MEM && !mem_ready)) begin
                hcnt <= hcnt + 5'h01;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_q || !ce);

    strobe_addr_a: assert property (!memory_cycle_strobe_n |-> addr_o[13:1] == op.addr)
        else $error("memory address not valid with strobe");
    byte_pair_a: assert property ((st == S_MEM && !byte_q && mem_ready) |=> (st == S_MEM && addr_o[0]))
        else $error("second byte cycle missing");
    read_dir_a: assert property (!memory_cycle_strobe_n |-> bus_input_direction == (op.kind == K_RD))
        else $error("input direction wrong in memory cycle");
    read_we_a: assert property (bus_input_direction |-> write_strobe_n)
        else $error("write strobe active in read");
    wait_hold_a: assert property ((st == S_MEM && !mem_ready) |=> (st == S_MEM && $stable(addr_o)))
        else $error("cycle not stretched while not ready");
    read_turn_a: assert property ((st == S_MEM && byte_q && mem_ready && op.kind == K_RD)
                                  |=> (!data_oe && memory_cycle_strobe_n && !bus_input_direction))
        else $error("no input turnaround clock");
    write_data_a: assert property (!write_strobe_n |-> (data_oe && !memory_cycle_strobe_n))
        else $error("write strobe without data");
    hold_enter_a: assert property ((st == S_IDLE && !hold_req_n) |=> ##0 bus_release_ack)
        else $error("hold not entered from idle");
    hold_float_a: assert property (bus_release_ack |-> (!bus_oe && !data_oe))
        else $error("buses driven in hold");
    hold_leave_a: assert property ((st == S_HOLD && hold_req_n) |=> !bus_release_ack)
        else $error("hold not left");
    hold_lat_a: assert property (hcnt <= HOLD_MAX_CLK)
        else $error("hold latency too long");
    bit_resume_a: assert property ((st == S_HOLD && hold_req_n && resume) |=> st == S_BRE ##1 st == S_BADR)
        else $error("bit address not reasserted");
    bit_strobe_a: assert property (bit_io_strobe |-> (op.kind == K_BOUT && $past(st) == S_BADR))
        else $error("bit strobe out of place");
    irq_latch_a: assert property ((ph == PH1 && agree) |=> int_level == $past(s2))
        else $error("agreed code not latched");

    cover_read_c:  cover property (st == S_TURN);
    cover_write_c: cover property (!write_strobe_n && addr_o[0]);
    cover_hold_c:  cover property (bus_release_ack && resume);
    cover_bit_c:   cover property (bit_io_strobe ##2 bit_io_strobe);

endmodule // ceb_bus_if
`default_nettype wire

// [inc/ceb_pkg.sv]
`default_nettype none
package ceb_pkg;

    // Clock rate and hold latency figures
    localparam int CLK_PERIOD_NS  = 20;
    localparam int HOLD_SETUP_CLK = 1;
    localparam int HOLD_BASE_CLK  = 12;
    localparam int HOLD_WAIT_MUL  = 6;
    localparam int HOLD_MAX_CLK   = HOLD_SETUP_CLK + HOLD_BASE_CLK;

    // Four-phase internal clock codes
    localparam logic [1:0] PH1 = 2'h0;
    localparam logic [1:0] PH2 = 2'h1;
    localparam logic [1:0] PH3 = 2'h2;
    localparam logic [1:0] PH4 = 2'h3;

    // Reset values of pins and counters
    localparam logic [13:0] ADDR_RST = 14'h0000;
    localparam logic [7:0]  DATA_RST = 8'h00;
    localparam logic [2:0]  LVL_RST  = 3'h0;
    localparam logic [3:0]  BIDX_RST = 4'h0;

    // Kind of core request
    typedef enum logic [1:0] {
        K_RD   = 2'b00,
        K_WR   = 2'b01,
        K_BOUT = 2'b10,
        K_BIN  = 2'b11
    } ceb_kind_e;

    // Bus engine states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_MEM  = 3'b001,
        S_TURN = 3'b010,
        S_HOLD = 3'b011,
        S_BADR = 3'b100,
        S_BSTB = 3'b101,
        S_BRE  = 3'b110
    } ceb_state_e;

    // Core request: word address, write word or bit data, bit count
    typedef struct packed {
        ceb_kind_e   kind;
        logic [12:0] addr;
        logic [15:0] wdata;
        logic [3:0]  cnt;
    } ceb_req_s;

endpackage
`default_nettype wire

// [sim/ceb_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ceb_far_model (
    // Clock and wait setting
    input  wire logic        ref_clk,
    input  wire logic [1:0]  waits,
    // Memory bus seen from the far side
    input  wire logic [13:0] addr_o,
    input  wire logic        bus_oe,
    input  wire logic [7:0]  data_o,
    input  wire logic        data_oe,
    input  wire logic        memory_cycle_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        bus_input_direction,
    output logic [7:0]       data_i,
    output logic             mem_ready,
    output logic             bit_in
);
    logic [7:0] mem [0:16383];
    logic [7:0] last;
    logic [1:0] wcnt;
    logic       sel;

    // Preset contents, same pattern the bench shadows
    initial begin
        for (int i = 0; i < 16384; i++) mem[i] = 8'(i) ^ 8'h3c;
        last = 8'h00;
        wcnt = 2'h0;
    end

    // Slow memory holds ready low for the set number of clocks per byte
    assign sel = !memory_cycle_strobe_n && bus_oe;
    assign mem_ready = !sel || (wcnt >= waits);

    // Wait counter and byte writes
    always @(posedge ref_clk) begin
        if (sel) wcnt <= mem_ready ? 2'h0 : wcnt + 2'h1;
        if (sel && mem_ready && !write_strobe_n && data_oe) mem[addr_o] <= data_o;
        if (bus_input_direction && sel) last <= data_i;
    end

    // Data only while selected for read, scrambled otherwise
    assign data_i = (bus_input_direction && sel) ? mem[addr_o] : ~last;
    // Bit source is the parity of the bit address
    assign bit_in = bus_oe ? ^addr_o[11:1] : ~last[0];
endmodule // ceb_far_model
`default_nettype wire

// [sim/ceb_bus_if_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module ceb_bus_if_bench;
    import ceb_pkg::*;
    logic        ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, rsp_ready = 1'b0, hold_req_n = 1'b1;
    logic        ce = 1'b1;
    logic [2:0]  interrupt_level_code = 3'h0;
    ceb_req_s    req = '0;
    logic        req_ready, rsp_valid, bus_oe, data_oe, memory_cycle_strobe_n, write_strobe_n;
    logic        bus_input_direction, mem_ready, bus_release_ack, bit_io_strobe, bit_in, phase3_n;
    logic [15:0] rsp_data, wd;
    logic [13:0] addr_o;
    logic [7:0]  data_i, data_o;
    logic [2:0]  int_level;
    logic [1:0]  waits = 2'h0;
    logic [12:0] base;
    logic [31:0] exp;
    ceb_kind_e   kind = K_RD;
    ceb_req_s    r;
    int          fails = 0, num_checks = 0, pulses = 0, nbits = 0;
    bit          stall = 1'b0;
    logic [7:0]  shadow [0:16383];
    logic [13:0] byte_q [$];
    logic [7:0]  wd_q [$];
    logic [31:0] rsp_q [$];
    localparam ceb_req_s CORNER [6] = '{'{K_BOUT, 13'h07ff, 16'ha5c3, 4'h0}, '{K_BOUT, 13'h0000, 16'h0001, 4'h1},
        '{K_BIN, 13'h07fe, 16'h0000, 4'h0}, '{K_BIN, 13'h0100, 16'h0000, 4'h3},
        '{K_WR, 13'h1fff, 16'hbeef, 4'h0}, '{K_RD, 13'h1fff, 16'h0000, 4'h0}};

    ceb_bus_if i_ceb_bus_if (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
        .addr_o(addr_o), .bus_oe(bus_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
        .memory_cycle_strobe_n(memory_cycle_strobe_n), .write_strobe_n(write_strobe_n),
        .bus_input_direction(bus_input_direction), .mem_ready(mem_ready), .hold_req_n(hold_req_n),
        .bus_release_ack(bus_release_ack), .bit_io_strobe(bit_io_strobe), .bit_in(bit_in),
        .interrupt_level_code(interrupt_level_code), .int_level(int_level), .phase3_n(phase3_n));
    ceb_far_model i_ceb_far_model (.ref_clk(ref_clk), .waits(waits), .addr_o(addr_o), .bus_oe(bus_oe),
        .data_o(data_o), .data_oe(data_oe), .memory_cycle_strobe_n(memory_cycle_strobe_n),
        .write_strobe_n(write_strobe_n), .bus_input_direction(bus_input_direction), .data_i(data_i),
        .mem_ready(mem_ready), .bit_in(bit_in));

    // Clock
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    // Answer taker with random stalls
    always @(negedge ref_clk) rsp_ready <= !stall && ($urandom_range(0, 3) != 0);

    // Expected bit-in word, mask in upper half
    function automatic logic [31:0] bin_exp(input logic [10:0] a, input int n);
        logic [31:0] e;
        e = '0;
        for (int i = 0; i < n; i++) begin
            e[16 + i] = 1'b1;
            e[i] = ^(a + 11'(i));
        end
        return e;
    endfunction

    // Bus monitor and answer checker, idle while the design is frozen
    always @(posedge ref_clk) if (ce) begin
        if (!memory_cycle_strobe_n && mem_ready && bus_oe) begin
            byte_q.push_back(addr_o);
            if (!write_strobe_n) wd_q.push_back(data_o);
        end
        if (bus_input_direction === 1'b1) `CHK(write_strobe_n, 1'b1)
        if (bit_io_strobe === 1'b1) begin
            `CHK(addr_o[11:1], base[10:0] + 11'(pulses))
            `CHK(addr_o[0], wd[pulses[3:0]])
            pulses++;
        end
        if (rsp_valid === 1'b1 && rsp_ready) begin
            exp = rsp_q.pop_front();
            `CHK(rsp_data & exp[31:16], exp[15:0])
        end
    end

    // Present one request and let the take edge pass
    task automatic issue(input ceb_req_s q);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (!(req_ready === 1'b1 && hold_req_n) && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 500) fails++;
        kind = q.kind;
        base = q.addr;
        wd = q.wdata;
        nbits = (q.cnt == 4'h0) ? 16 : int'(q.cnt);
        pulses = 0;
        byte_q.delete();
        wd_q.delete();
        if (q.kind == K_WR) begin
            shadow[{q.addr, 1'b0}] = q.wdata[15:8];
            shadow[{q.addr, 1'b1}] = q.wdata[7:0];
        end
        if (q.kind == K_RD) rsp_q.push_back({16'hffff, shadow[{q.addr, 1'b0}], shadow[{q.addr, 1'b1}]});
        if (q.kind == K_BIN) rsp_q.push_back(bin_exp(q.addr[10:0], nbits));
        req = q;
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask

    // Wait for the engine to go idle and check the transfer
    task automatic finish();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 500) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(req_ready, 1'b1)
        if (kind == K_RD || kind == K_WR) begin
            `CHK(byte_q.size(), 2)
            `CHK(byte_q[0], {base, 1'b0})
            `CHK(byte_q[1], {base, 1'b1})
        end else `CHK(pulses, (kind == K_BOUT) ? nbits : 0)
        if (kind == K_WR) `CHK({wd_q[0], wd_q[1]}, wd)
    endtask

    // Hold request in the middle of a transfer
    task automatic hold_mid(input ceb_req_s q);
        int n;
        n = 0;
        issue(q);
        hold_req_n = 1'b0;
        while (bus_release_ack !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(n <= HOLD_MAX_CLK + HOLD_WAIT_MUL * int'(waits), 1'b1)
        `CHK(bus_oe, 1'b0)
        repeat (4) @(negedge ref_clk);
        hold_req_n = 1'b1;
        finish();
        `CHK(bus_release_ack, 1'b0)
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(CLK_PERIOD_NS * 40000);
        fails++;
        complete_run();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 16384; i++) shadow[i] = 8'(i) ^ 8'h3c;
        void'($urandom(43));
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        // Corner cases: count ends, write then read back
        foreach (CORNER[i]) begin
            issue(CORNER[i]);
            finish();
        end
        // Random traffic with random wait states
        for (int i = 0; i < 60; i++) begin
            waits = 2'($urandom_range(0, 2));
            r = '{ceb_kind_e'($urandom_range(0, 3)), 13'($urandom), 16'($urandom), 4'($urandom)};
            issue(r);
            // Freeze the engine for two clocks in its first transfer clock
            ce = 1'b0;
            repeat (2) @(negedge ref_clk);
            ce = 1'b1;
            finish();
        end
        // Hold during a slow read and during a bit output
        waits = 2'h2;
        hold_mid('{K_RD, 13'h0abc, 16'h0000, 4'h0});
        hold_mid('{K_BOUT, 13'h0123, 16'h5a5a, 4'h5});
        // Fill the answer buffer until it refuses, then drain
        stall = 1'b1;
        issue('{K_RD, 13'h0010, 16'h0000, 4'h0});
        finish();
        issue('{K_BIN, 13'h0020, 16'h0000, 4'h2});
        repeat (12) @(negedge ref_clk);
        `CHK(req_ready, 1'b0)
        stall = 1'b0;
        finish();
        // Interrupt codes changed in step with phase three
        for (int l = 1; l < 8; l++) begin
            @(negedge phase3_n);
            @(negedge ref_clk);
            interrupt_level_code = 3'(l);
            repeat (8) @(negedge ref_clk);
            `CHK(int_level, 3'(l))
        end
        repeat (20) @(negedge ref_clk);
        `CHK(rsp_q.size(), 0)
        complete_run();
    end
endmodule // ceb_bus_if_bench
`default_nettype wire
